// ---- dsl_host_model.sv ----
`timescale 1ns/1ns
module dsl_host_model
	import dsl_pkg::*;
#(
	parameter int unsigned BIT_NS = 80
)(
	input wire logic txdPin,
	output logic rxdPin,
	output logic ctsPin
);
	logic [7:0] rxq[$];
	time rxt[$];
	initial
	begin
		rxdPin = 1'b1;
		ctsPin = 1'b1;
	end
	// Even parity, LSB first, one stop; badPar spoils parity
	task automatic put_char(input logic [6:0] c, input logic badPar);
		logic [9:0] f;
		f = {1'b1, ^c ^ badPar, c, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxdPin = f[i];
			#(BIT_NS);
		end
	endtask
	// Fixed control codes, XOR check over the whole frame
	task automatic send_cmd(input logic [6:0] id, hd, cmd, input logic badBcc, badPar);
		logic [6:0] m[5];
		logic [6:0] x;
		m = '{CH_EOT, id, hd, cmd, CH_ETX};
		x = 7'h00;
		foreach (m[i])
		begin
			put_char(m[i], badPar && i == 3);
			x ^= m[i];
		end
		put_char(x ^ {6'h00, badBcc}, 1'b0);
	endtask
	// Bit 7 flags a parity or stop fault
	always @(negedge txdPin)
	begin : rx_frame
		logic [9:0] f;
		rxt.push_back($time);
		#(BIT_NS / 2);
		for (int i = 0; i < 10; i++)
		begin
			f[i] = txdPin;
			if (i < 9)
				#(BIT_NS);
		end
		rxq.push_back({~f[9] | ^f[8:1], f[7:1]});
	end
endmodule // dsl_host_model

// ---- dsl_link.sv ----
// Notes on behaviour
// R1: 4800 bps, 7 data, even parity, 1 stop
// R2: Fixed control codes and identity 30..33
// R3: Sent messages end with XOR check character
// R4: Good check gets ACK, bad gets NAK
// R5: NAK code 15; resend until ACK arrives
// R6: Parity-bad character becomes NUL, forcing rejection
// R7: Awaiting ACK: other than ACK/EOT means NAK
// R8: Half duplex; silent during purge or dispense
// R9: One command at a time; nothing unsolicited
// R10: Hold command 500 ms; newer command replaces
// R11: Host ends retries with ACK or EOT
// R12: Reply sent 50..100 ms after message, CTS on
// R13: Operation starts at least 500 ms after ACK
// R14: ACK wait times out between 500..550 ms
// R15: Transmit within 0..50 ms of CTS
// R16: Polled reply starts 50..100 ms after poll
// R17: RTS off within 100 ms; no receive meanwhile
// R18: Exit-count RTS pulses last 50..100 ms
// R19: Host waits 550 ms before assuming ignored; the testbench host moves on after 120 ms
// R20: Host resends 100..300 ms after NAK
// R21: Host answers 100..500 ms after message
// R22: Host waits 100 ms after EOT
// R23: Raise RTS to send; hold while CTS off
// R24: Poll is EOT, identity, ENQ
// R25: Windows timed by restartable millisecond tick
`timescale 1ns/1ns
module dsl_link
	import dsl_pkg::*;
#(
	parameter int unsigned BIT_CYC = BIT_CYC_DEF,
	parameter int unsigned MS_CYC = MS_CYC_DEF
)(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic rxdPin,
	input wire logic ctsPin,
	input wire logic pollMode,
	input wire logic [1:0] commId,
	input wire logic opBusy,
	input wire logic noteExit,
	input wire logic rspValid,
	input wire logic [6:0] rspData,
	input wire logic rspLast,
	output logic rspReady,
	output logic txdPin,
	output logic rtsPin,
	output logic cmdGo,
	output logic [6:0] cmdCode,
	output logic rspDone
);
	// Pin synchronisers
	logic [4:0] pinMeta;
	logic [4:0] pinSync;
	logic rxLine;
	logic ctsOn;
	logic polled;
	logic [6:0] myId;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinMeta <= 5'h1F;
			pinSync <= 5'h1F;
		end
		else
		begin
			pinMeta <= {commId, pollMode, ctsPin, rxdPin};
			pinSync <= pinMeta;
		end
	end
	assign rxLine = pinSync[0];
	assign ctsOn = pinSync[1];
	assign polled = pinSync[2];
	assign myId = CH_ID_BASE | {5'h00, pinSync[4:3]}; // [R2]

	// Receiver
	logic rxPrev;
	logic rxBusy;
	logic [3:0] rxBit;
	logic [PRE_W-1:0] rxDiv;
	logic [8:0] rxShift;
	logic rxDone;
	logic [6:0] rxChar;
	logic rxBad;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxPrev <= 1'b1;
			rxBusy <= 1'b0;
			rxBit <= 4'h0;
			rxDiv <= '0;
			rxShift <= 9'h000;
			rxDone <= 1'b0;
			rxChar <= CH_NUL;
			rxBad <= 1'b0;
		end
		else
		begin
			rxPrev <= rxLine;
			rxDone <= 1'b0;
			if (!rxBusy)
			begin
				// Own transmissions echo nothing back: receive only with RTS off
				if (rxPrev && !rxLine && !rtsPin) // [R17]
				begin
					rxBusy <= 1'b1;
					rxBit <= 4'h0;
					rxDiv <= PRE_W'(BIT_CYC / 2);
				end
			end
			else if (rxDiv != '0)
				rxDiv <= rxDiv - 1'b1;
			else
			begin
				rxDiv <= PRE_W'(BIT_CYC - 1);
				rxBit <= rxBit + 4'h1;
				if (rxBit == 4'h0 && rxLine)
					rxBusy <= 1'b0;
				else if (rxBit != FRAME_LAST - 4'h1)
					rxShift <= {rxLine, rxShift[8:1]}; // [R1]
				else
				begin
					rxBusy <= 1'b0;
					rxDone <= 1'b1;
					rxBad <= (^rxShift) || !rxLine; // [R1]
					// Slot 0 holds the start bit, so data sits one place up
					rxChar <= ((^rxShift) || !rxLine) ? CH_NUL : rxShift[7:1]; // [R6]
				end
			end
		end
	end

	// Transmitter
	logic txGo;
	logic [6:0] txChar;
	logic txBusy;
	logic txDone;
	logic [3:0] txBit;
	logic [PRE_W-1:0] txDiv;
	logic [9:0] txShift;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txBusy <= 1'b0;
			txDone <= 1'b0;
			txBit <= 4'h0;
			txDiv <= '0;
			txShift <= 10'h3FF;
			txdPin <= 1'b1;
		end
		else
		begin
			txDone <= 1'b0;
			if (txGo)
			begin
				txBusy <= 1'b1;
				txBit <= 4'h0;
				txDiv <= PRE_W'(BIT_CYC - 1);
				txShift <= {1'b1, ^txChar, txChar, 1'b0}; // [R1]
				txdPin <= 1'b0;
			end
			else if (txBusy)
			begin
				if (txDiv != '0)
					txDiv <= txDiv - 1'b1;
				else if (txBit == FRAME_LAST - 4'h1)
				begin
					txBusy <= 1'b0;
					txDone <= 1'b1;
				end
				else
				begin
					txDiv <= PRE_W'(BIT_CYC - 1);
					txBit <= txBit + 4'h1;
					txShift <= {1'b1, txShift[9:1]};
					txdPin <= txShift[1];
				end
			end
		end
	end

	// Link sequencer
	dsl_link_t state;
	dsl_link_t next_state;
	logic [PRE_W-1:0] tmrPre;
	logic [9:0] tmr;
	logic [6:0] replyChar;
	logic [6:0] next_replyChar;
	logic cmdOk;
	logic cmdBad;
	logic pollSeen;
	logic msgReady;
	logic rspOwed;
	logic [MSG_AW:0] msgLen;
	logic [MSG_AW:0] txIdx;
	logic [6:0] msgBcc;
	logic lastSent;
	logic [7:0] pulsePend;
	logic bufValid;
	logic [BUF_W-1:0] bufData;
	logic bufPop;
	logic sendState;
	logic ackGot;
	logic [6:0] msgMem [MSG_DEPTH];

	assign sendState = state == LK_REPLY_SEND || state == LK_MSG_SEND;
	assign txGo = sendState && !txBusy && !lastSent;
	assign txChar = state == LK_REPLY_SEND ? replyChar
		: (txIdx == msgLen ? msgBcc : msgMem[txIdx[MSG_AW-1:0]]); // [R3]
	assign bufPop = state == LK_LOAD && bufValid;
	// Only ACK or EOT closes the exchange; a NUL from bad parity cannot
	assign ackGot = rxChar == CH_ACK || rxChar == CH_EOT; // [R7] [R11]

	dsl_skid #(
		.W(BUF_W)
	) rspBuf (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.inValid(rspValid),
		.inData({rspLast, rspData}),
		.inReady(rspReady),
		.outValid(bufValid),
		.outData(bufData),
		.outReady(bufPop)
	);

	always_comb
	begin
		next_state = state;
		next_replyChar = replyChar;
		unique case (state)
			LK_IDLE:
			begin
				if (opBusy) // [R8]
				begin
					if (pulsePend != 8'h00)
						next_state = LK_PULSE_HI;
				end
				else if (cmdOk || cmdBad)
				begin
					next_state = LK_REPLY_WAIT;
					next_replyChar = cmdOk ? CH_ACK : CH_NAK; // [R4] [R5]
				end
				else if (polled && pollSeen) // [R24]
				begin
					next_state = msgReady ? LK_MSG_WAIT : LK_REPLY_WAIT;
					next_replyChar = CH_EOT;
				end
				else if (rspOwed && !msgReady && bufValid) // [R9]
					next_state = LK_LOAD;
				else if (!polled && msgReady)
					next_state = LK_MSG_WAIT;
				else if (pulsePend != 8'h00)
					next_state = LK_PULSE_HI;
			end
			LK_REPLY_WAIT:
				if (tmr >= REPLY_DLY_MS && ctsOn) // [R12] [R23]
					next_state = LK_REPLY_SEND;
			LK_REPLY_SEND:
				if (txDone && lastSent)
					next_state = LK_IDLE;
			LK_LOAD:
				if (bufPop && bufData[BUF_W-1])
					next_state = LK_IDLE;
			LK_MSG_WAIT:
				if (tmr >= (polled ? POLL_DLY_MS : CTS_DLY_MS) && ctsOn) // [R15] [R16] [R23]
					next_state = LK_MSG_SEND;
			LK_MSG_SEND:
				if (txDone && lastSent)
					next_state = LK_ACK_WAIT;
			LK_ACK_WAIT:
				if (rxDone)
					next_state = ackGot ? LK_IDLE : LK_MSG_WAIT; // [R5] [R7]
				else if (tmr >= ACK_TO_MS) // [R14]
					next_state = LK_MSG_WAIT;
			LK_PULSE_HI:
				if (tmr >= PULSE_MS) // [R18]
					next_state = LK_PULSE_LO;
			LK_PULSE_LO:
				if (tmr >= PULSE_GAP_MS)
					next_state = LK_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= LK_IDLE;
			replyChar <= CH_NAK;
			rtsPin <= 1'b0;
		end
		else
		begin
			state <= next_state;
			replyChar <= next_replyChar;
			// RTS drops the cycle after the last stop bit
			rtsPin <= next_state == LK_REPLY_WAIT || next_state == LK_REPLY_SEND
				|| next_state == LK_MSG_WAIT || next_state == LK_MSG_SEND
				|| next_state == LK_PULSE_HI; // [R17] [R23]
		end
	end

	// Window timer, restarted with its prescaler on every state change
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tmrPre <= '0;
			tmr <= 10'h000;
		end
		else if (next_state != state) // [R25]
		begin
			tmrPre <= '0;
			tmr <= 10'h000;
		end
		else if (tmrPre == PRE_W'(MS_CYC - 1))
		begin
			tmrPre <= '0;
			if (tmr != MS_SAT)
				tmr <= tmr + 10'h001;
		end
		else
			tmrPre <= tmrPre + 1'b1;
	end

	// Message parser, live only while idle
	dsl_parse_t pst;
	logic [6:0] rxBcc;
	logic [6:0] cmdTmp;
	logic rxTaint;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pst <= PR_IDLE;
			rxBcc <= CH_NUL;
			cmdTmp <= CH_NUL;
			rxTaint <= 1'b0;
			cmdOk <= 1'b0;
			cmdBad <= 1'b0;
			pollSeen <= 1'b0;
		end
		else
		begin
			cmdOk <= 1'b0;
			cmdBad <= 1'b0;
			pollSeen <= 1'b0;
			if (state != LK_IDLE || opBusy) // [R8] [R9]
				pst <= PR_IDLE;
			else if (rxDone)
			begin
				rxBcc <= rxBcc ^ rxChar; // [R3]
				if (rxBad)
					rxTaint <= 1'b1; // [R6]
				unique case (pst)
					PR_IDLE:
						if (rxChar == CH_EOT) // [R2]
						begin
							pst <= PR_ID;
							rxBcc <= rxChar;
							rxTaint <= 1'b0;
						end
					PR_ID:
						pst <= rxChar == myId ? PR_KIND : PR_IDLE;
					PR_KIND:
						if (rxChar == CH_ENQ) // [R24]
						begin
							pollSeen <= 1'b1;
							pst <= PR_IDLE;
						end
						else
						begin
							// Garbled text start still earns a NAK
							rxTaint <= rxTaint || rxChar != CH_STX;
							pst <= PR_CMD;
						end
					PR_CMD:
					begin
						cmdTmp <= rxChar;
						pst <= rxChar == CH_ETX ? PR_BCC : PR_BODY;
					end
					PR_BODY:
						if (rxChar == CH_ETX)
							pst <= PR_BCC;
					PR_BCC:
					begin
						pst <= PR_IDLE;
						cmdOk <= !rxTaint && !rxBad && rxChar == rxBcc; // [R4]
						cmdBad <= rxTaint || rxBad || rxChar != rxBcc; // [R4] [R6]
					end
				endcase
			end
		end
	end

	// Response store; kept for resends until the host closes it
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			msgReady <= 1'b0;
			msgLen <= '0;
			msgBcc <= CH_NUL;
			rspDone <= 1'b0;
		end
		else
		begin
			rspDone <= 1'b0;
			if (bufPop)
			begin
				msgBcc <= (msgLen == '0 ? CH_NUL : msgBcc) ^ bufData[6:0]; // [R3]
				// Words past the store depth are dropped
				if (msgLen != (MSG_AW + 1)'(MSG_DEPTH))
					msgLen <= msgLen + 1'b1;
				if (bufData[BUF_W-1])
					msgReady <= 1'b1;
			end
			else if (state == LK_ACK_WAIT && rxDone && ackGot) // [R11]
			begin
				msgReady <= 1'b0;
				msgLen <= '0;
				rspDone <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (bufPop && msgLen != (MSG_AW + 1)'(MSG_DEPTH))
			msgMem[msgLen[MSG_AW-1:0]] <= bufData[6:0];
	end

	// Character walk through a send
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txIdx <= '0;
			lastSent <= 1'b0;
		end
		else if (!sendState)
		begin
			txIdx <= '0;
			lastSent <= 1'b0;
		end
		else if (txGo)
		begin
			txIdx <= txIdx + 1'b1;
			lastSent <= state == LK_REPLY_SEND || txIdx == msgLen; // [R3]
		end
	end

	// Command hold; a later ACK restarts the window with the new code
	logic [PRE_W-1:0] holdPre;
	logic [9:0] holdMs;
	logic holdOn;
	logic [6:0] holdCode;
	logic ackSent;

	assign ackSent = state == LK_REPLY_SEND && txDone && lastSent && replyChar == CH_ACK;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			holdPre <= '0;
			holdMs <= 10'h000;
			holdOn <= 1'b0;
			holdCode <= CH_NUL;
			cmdGo <= 1'b0;
			cmdCode <= CH_NUL;
			rspOwed <= 1'b0;
		end
		else
		begin
			cmdGo <= 1'b0;
			if (ackSent) // [R10]
			begin
				holdPre <= '0;
				holdMs <= 10'h000;
				holdOn <= 1'b1;
				holdCode <= cmdTmp;
				rspOwed <= 1'b1; // [R9]
			end
			else if (holdOn)
			begin
				if (holdMs == HOLD_MS) // [R10] [R13]
				begin
					holdOn <= 1'b0;
					cmdGo <= 1'b1;
					cmdCode <= holdCode;
				end
				else if (holdPre == PRE_W'(MS_CYC - 1))
				begin
					holdPre <= '0;
					holdMs <= holdMs + 10'h001;
				end
				else
					holdPre <= holdPre + 1'b1;
			end
			if (!ackSent && rspDone)
				rspOwed <= 1'b0;
		end
	end

	// Exit-count pulses waiting for RTS
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			pulsePend <= 8'h00;
		else if (noteExit && !(state == LK_PULSE_LO && next_state == LK_IDLE))
		begin
			if (pulsePend != 8'hFF)
				pulsePend <= pulsePend + 8'h01;
		end
		else if (!noteExit && state == LK_PULSE_LO && next_state == LK_IDLE)
			pulsePend <= pulsePend - 8'h01; // [R18]
	end
endmodule // dsl_link

// ---- dsl_link_assertions.sv ----
`timescale 1ns/1ns
module dsl_link_assertions #(
	parameter int unsigned BIT_CYC = 8,
	parameter int unsigned MS_CYC = 10
)(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic ctsPin,
	input wire logic opBusy,
	input wire logic txdPin,
	input wire logic rtsPin,
	input wire logic cmdGo,
	input wire logic rspDone
);
	logic [31:0] rtsIdle;
	logic [31:0] hiCnt;
	logic [31:0] txQuiet;
	logic sent;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Time rts stands high with the line idle
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rtsIdle <= '0;
		else if (rtsPin && txdPin)
			rtsIdle <= rtsIdle + 1;
		else
			rtsIdle <= '0;
	end
	// Pulse width; frames set sent so replies are not taken for pulses
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hiCnt <= '0;
			sent <= 1'b0;
		end
		else if (!rtsPin)
		begin
			hiCnt <= '0;
			sent <= 1'b0;
		end
		else
		begin
			hiCnt <= hiCnt + 1;
			sent <= sent | !txdPin;
		end
	end
	// Saturating, so a long quiet spell never wraps round
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			txQuiet <= '0;
		else if (!txdPin)
			txQuiet <= '0;
		else if (txQuiet != '1)
			txQuiet <= txQuiet + 1;
	end
	a_tx_rts: assert property (!txdPin |-> rtsPin)
		else $error("txd active without rts");
	a_tx_cts: assert property ($fell(txdPin) |-> ctsPin)
		else $error("frame started with cts off");
	a_rts_idle: assert property (rtsIdle < 100 * MS_CYC)
		else $error("rts held idle too long");
	a_pulse_width: assert property ($fell(rtsPin) && !sent |->
		hiCnt >= 50 * MS_CYC && hiCnt <= 100 * MS_CYC)
		else $error("exit pulse width out of window");
	a_go_hold: assert property (cmdGo |-> txQuiet >= 500 * MS_CYC)
		else $error("command released too early");
	a_go_pulse: assert property (cmdGo |=> !cmdGo)
		else $error("cmdGo longer than one cycle");
	a_done_pulse: assert property (rspDone |=> !rspDone)
		else $error("rspDone longer than one cycle");
	a_busy_silent: assert property (opBusy |-> txdPin)
		else $error("transmit while busy");
	cover property (cmdGo);
	cover property (rspDone);
	cover property ($fell(rtsPin) && !sent);
endmodule // dsl_link_assertions

// ---- dsl_pkg.sv ----
package dsl_pkg;
	// Character coding
	localparam int unsigned CHAR_W = 7;
	localparam logic [6:0] CH_NUL = 7'h00;
	localparam logic [6:0] CH_SOH = 7'h01;
	localparam logic [6:0] CH_STX = 7'h02;
	localparam logic [6:0] CH_ETX = 7'h03;
	localparam logic [6:0] CH_EOT = 7'h04;
	localparam logic [6:0] CH_ENQ = 7'h05;
	localparam logic [6:0] CH_ACK = 7'h06;
	localparam logic [6:0] CH_NAK = 7'h15;
	localparam logic [6:0] CH_ID_BASE = 7'h30;

	// Clock and line rate
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD = 4800;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned BIT_CYC_DEF = CLK_HZ / BAUD;
	localparam int unsigned MS_CYC_DEF = CLK_HZ / MS_PER_S;
	localparam int unsigned PRE_W = 17;
	localparam logic [3:0] FRAME_LAST = 4'hA;

	// Millisecond windows and the points chosen inside them
	localparam int unsigned MS_W = 10;
	localparam logic [9:0] REPLY_MIN_MS = 10'h032;
	localparam logic [9:0] REPLY_MAX_MS = 10'h064;
	localparam logic [9:0] REPLY_DLY_MS = REPLY_MIN_MS + 10'h00A;
	localparam logic [9:0] POLL_DLY_MS = REPLY_MIN_MS + 10'h00A;
	localparam logic [9:0] CTS_DLY_MS = 10'h000;
	localparam logic [9:0] HOLD_MS = 10'h1F4;
	localparam logic [9:0] ACK_TO_MIN_MS = 10'h1F4;
	localparam logic [9:0] ACK_TO_MAX_MS = 10'h226;
	localparam logic [9:0] ACK_TO_MS = ACK_TO_MIN_MS + 10'h019;
	localparam logic [9:0] PULSE_MS = 10'h04B;
	localparam logic [9:0] PULSE_GAP_MS = 10'h04B;
	localparam logic [9:0] MS_SAT = 10'h3FF;

	// Response message store
	localparam int unsigned MSG_DEPTH = 16;
	localparam int unsigned MSG_AW = 4;
	localparam int unsigned BUF_W = CHAR_W + 1;

	typedef enum logic [3:0] {
		LK_IDLE, LK_REPLY_WAIT, LK_REPLY_SEND, LK_LOAD, LK_MSG_WAIT,
		LK_MSG_SEND, LK_ACK_WAIT, LK_PULSE_HI, LK_PULSE_LO
	} dsl_link_t;

	typedef enum logic [2:0] {
		PR_IDLE, PR_ID, PR_KIND, PR_CMD, PR_BODY, PR_BCC
	} dsl_parse_t;
endpackage

// ---- dsl_skid.sv ----
`timescale 1ns/1ns
module dsl_skid
	import dsl_pkg::*;
#(
	parameter int unsigned W = BUF_W
)(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady
);
	logic [W-1:0] slot [2];
	logic wrPtr;
	logic rdPtr;
	logic [1:0] fill;
	logic push;
	logic pop;
	logic [1:0] next_fill;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outValid = fill != 2'h0;
	assign outData = slot[rdPtr];

	always_comb
	begin
		next_fill = fill;
		if (push && !pop)
			next_fill = fill + 2'h1;
		else if (pop && !push)
			next_fill = fill - 2'h1;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fill <= 2'h0;
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			inReady <= 1'b0;
		end
		else
		begin
			fill <= next_fill;
			// Ready is a flop, so it looks one cycle ahead
			inReady <= next_fill != 2'h2;
			if (push)
				wrPtr <= !wrPtr;
			if (pop)
				rdPtr <= !rdPtr;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (push)
			slot[wrPtr] <= inData;
	end
endmodule // dsl_skid

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
	import dsl_pkg::*;
	localparam int unsigned MSC = 10;
	localparam int unsigned BC = 8;
	localparam time MS = MSC * 10;
	localparam time CH = BC * 100;
	typedef struct packed {
		logic [6:0] id;
		logic [6:0] hd;
		logic [6:0] cmd;
		logic badBcc;
		logic badPar;
		logic [6:0] rep;
	} dsl_row_t;
	// Reply 7F marks a frame that must be ignored
	dsl_row_t rows[5] = '{'{7'h33, CH_STX, 7'h40, 1'b0, 1'b0, CH_ACK},
		'{7'h33, CH_STX, 7'h41, 1'b1, 1'b0, CH_NAK}, '{7'h33, CH_STX, 7'h42, 1'b0, 1'b1, CH_NAK},
		'{7'h33, CH_SOH, 7'h43, 1'b0, 1'b0, CH_NAK}, '{7'h31, CH_STX, 7'h44, 1'b0, 1'b0, 7'h7F}};
	logic [6:0] msg[5] = '{CH_SOH, 7'h33, CH_STX, 7'h46, CH_ETX};
	logic [7:0] ans[4] = '{{1'b0, CH_NAK}, {1'b1, CH_ACK}, 8'hFF, 8'h41};
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic pollMode = 1'b0;
	logic opBusy = 1'b0;
	logic noteExit = 1'b0;
	logic rspValid = 1'b0;
	logic rspLast = 1'b0;
	logic [6:0] rspData = 7'h00;
	logic [1:0] commId = 2'h3;
	logic rxdPin, ctsPin, txdPin, rtsPin, cmdGo, rspReady, rspDone;
	logic [6:0] cmdCode;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	int goCnt = 0;
	int doneCnt = 0;
	int rtsUp = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge rtsPin) rtsUp++;
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		goCnt <= goCnt + int'(cmdGo);
		doneCnt <= doneCnt + int'(rspDone);
		if (cyc == 90000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	dsl_host_model #(.BIT_NS(BC * 10)) dsl_host_model_i (.txdPin(txdPin), .rxdPin(rxdPin),
		.ctsPin(ctsPin));
	dsl_link #(.BIT_CYC(BC), .MS_CYC(MSC)) dsl_link_i (.sys_clk(sys_clk), .arst_n(arst_n),
		.rxdPin(rxdPin), .ctsPin(ctsPin), .pollMode(pollMode), .commId(commId), .opBusy(opBusy),
		.noteExit(noteExit), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
		.rspReady(rspReady), .txdPin(txdPin), .rtsPin(rtsPin), .cmdGo(cmdGo),
		.cmdCode(cmdCode), .rspDone(rspDone));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic gap(input int ms);
		repeat (ms * MSC) @(negedge sys_clk);
	endtask
	// Waits long enough to span an acknowledge timeout
	task automatic get(input logic [6:0] c, output time t);
		int n;
		n = 0;
		t = 0;
		while (dsl_host_model_i.rxq.size() == 0 && n < 12000)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n < 12000)
			t = dsl_host_model_i.rxt.pop_front();
		chk(n < 12000 ? dsl_host_model_i.rxq.pop_front() : 8'hFF, {1'b0, c});
	endtask
	task automatic getMsg(output time tf, output time tl);
		logic [6:0] x;
		x = 7'h00;
		tf = 0;
		foreach (msg[i])
		begin
			get(msg[i], tl);
			x ^= msg[i];
			if (i == 0)
				tf = tl;
		end
		get(x, tl);
	endtask
	task automatic push(input logic [6:0] c, input logic last);
		int n;
		n = 0;
		@(negedge sys_clk);
		rspValid = 1'b1;
		rspData = c;
		rspLast = last;
		while (rspReady !== 1'b1 && n < 500)
		begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		rspValid = 1'b0;
	endtask
	task automatic waitGo(input int n0, output time tg);
		int n;
		n = 0;
		while (goCnt == n0 && n < 7000)
		begin
			@(negedge sys_clk);
			n++;
		end
		tg = $time;
	endtask
	initial
	begin
		time t, t0, tc, tl, tg;
		int n;
		repeat (6) @(negedge sys_clk);
		arst_n = 1'b1;
		gap(1);
		chk({4'h0, txdPin, rtsPin, cmdGo, rspDone}, 8'h08);
		foreach (rows[i])
		begin
			n = goCnt;
			dsl_host_model_i.send_cmd(rows[i].id, rows[i].hd, rows[i].cmd, rows[i].badBcc,
				rows[i].badPar);
			t0 = $time;
			if (rows[i].rep == 7'h7F)
				gap(120);
			else
			begin
				get(rows[i].rep, t);
				chk({7'h0, t - t0 >= 50 * MS && t - t0 <= 100 * MS}, 8'h01);
				if (rows[i].rep == CH_ACK)
				begin
					waitGo(n, tg);
					chk({1'b0, cmdCode}, {1'b0, rows[i].cmd});
					chk({7'h0, tg - t - CH >= 500 * MS}, 8'h01);
				end
				gap(150);
			end
			chk(8'(goCnt - n), {7'h0, rows[i].rep == CH_ACK});
		end
		// Second command inside the hold window replaces the first
		dsl_host_model_i.send_cmd(7'h33, CH_STX, 7'h45, 1'b0, 1'b0);
		get(CH_ACK, t);
		n = goCnt;
		gap(150);
		dsl_host_model_i.send_cmd(7'h33, CH_STX, 7'h46, 1'b0, 1'b0);
		get(CH_ACK, t);
		waitGo(n, tg);
		chk({1'b0, cmdCode}, 8'h46);
		chk({7'h0, tg - t - CH >= 500 * MS}, 8'h01);
		gap(100);
		chk(8'(goCnt - n), 8'h01);
		// Response held back by cts, then rejected three ways and timed out
		dsl_host_model_i.ctsPin = 1'b0;
		foreach (msg[i])
			push(msg[i], i == 4);
		gap(30);
		chk(8'(dsl_host_model_i.rxq.size()), 8'h00);
		tc = $time;
		dsl_host_model_i.ctsPin = 1'b1;
		getMsg(t0, tl);
		chk({7'h0, t0 - tc <= 50 * MS}, 8'h01);
		foreach (ans[k])
		begin
			gap(150);
			if (ans[k] != 8'hFF)
				dsl_host_model_i.put_char(ans[k][6:0], ans[k][7]);
			t = tl + CH;
			getMsg(t0, tl);
			if (ans[k] == 8'hFF)
				chk({7'h0, t0 - t >= 500 * MS && t0 - t <= 550 * MS}, 8'h01);
		end
		gap(150);
		n = doneCnt;
		dsl_host_model_i.put_char(CH_ACK, 1'b0);
		gap(5);
		chk(8'(doneCnt - n), 8'h01);
		// Stray EOT earns no reply; host spaces its next command
		dsl_host_model_i.put_char(CH_EOT, 1'b0);
		gap(100);
		// Busy link ignores commands; exit pulses still go out
		opBusy = 1'b1;
		dsl_host_model_i.send_cmd(7'h33, CH_STX, 7'h47, 1'b0, 1'b0);
		gap(120);
		chk(8'(dsl_host_model_i.rxq.size()), 8'h00);
		dsl_host_model_i.ctsPin = 1'b0;
		n = rtsUp;
		repeat (2)
		begin
			noteExit = 1'b1;
			@(negedge sys_clk);
			noteExit = 1'b0;
			@(negedge sys_clk);
		end
		gap(350);
		chk(8'(rtsUp - n), 8'h02);
		opBusy = 1'b0;
		dsl_host_model_i.ctsPin = 1'b1;
		pollMode = 1'b1;
		gap(1);
		dsl_host_model_i.put_char(CH_EOT, 1'b0);
		dsl_host_model_i.put_char(7'h33, 1'b0);
		dsl_host_model_i.put_char(CH_ENQ, 1'b0);
		t0 = $time;
		get(CH_EOT, t);
		chk({7'h0, t - t0 >= 50 * MS && t - t0 <= 100 * MS}, 8'h01);
		gap(150);
		// Unsolicited words stall the buffer once it holds two
		rspValid = 1'b1;
		rspData = CH_SOH;
		rspLast = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk({7'h0, rspReady}, 8'h00);
		rspValid = 1'b0;
		// Mid-run reset empties the stalled buffer
		arst_n = 1'b0;
		@(negedge sys_clk);
		chk({5'h0, txdPin, rtsPin, rspReady}, 8'h04);
		arst_n = 1'b1;
		gap(1);
		chk({7'h0, rspReady}, 8'h01);
		wrap_up();
	end
endmodule // testbench
bind dsl_link dsl_link_assertions #(.BIT_CYC(BIT_CYC), .MS_CYC(MS_CYC)) dsl_link_assertions_i (
	.sys_clk(sys_clk), .arst_n(arst_n), .ctsPin(ctsPin), .opBusy(opBusy), .txdPin(txdPin),
	.rtsPin(rtsPin), .cmdGo(cmdGo), .rspDone(rspDone));
